// *** rtl/acc_top.sv ***
// Converter clock generation, write locking and clock suspension control
//
// Notes on behaviour
// - Locked configuration writes are taken only while the enable is low, else ignored.
// - Register side runs on the bus clock; core runs on derived clock enables.
// - Source divider makes core source clock at most 40 MHz; zero passes through.
// - Core source clock drives both warmup prescaler and local timer.
// - Each of two groups holds a conversion divider; conversion uses its group's one.
// - Nonzero source divider with conversion divider zero forces divide by two.
// - Suspended clock restarts before warmup; idle clock stops if either scan or single suspend is set.
// - Suspended clock stops again once the waking conversion completes.
// - Immediate trigger with suspend: clock runs only while a queue is enabled.
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_top
  import acc_pkg::*;
#(
  parameter int SRC_DIV_W = `ACC_SRC_DIV_W,
  parameter int PRESC_W   = `ACC_PRESC_W
)
(
  input  wire logic                      CLK,
  input  wire logic                      RST_B,
  input  wire logic                      MODULE_EN,
  input  wire logic                      CFG_WR,
  input  wire acc_cfg_t                  CFG_WDATA,
  input  wire logic                      SCAN_QUEUE_EN,
  input  wire logic                      SINGLE_QUEUE_EN,
  input  wire logic                      CONV_REQ,
  input  wire logic                      CONV_REQ_SCAN,
  input  wire logic                      CONV_REQ_GRP,
  input  wire logic                      CONV_DONE,
  output acc_cfg_t                       CFG_RDATA,
  output logic                           CFG_WR_IGNORED,
  output logic                           CORE_EN,
  output logic                           SRC_CLK_EN,
  output logic                           WARMUP_PRESC_CLK_EN,
  output logic                           TIMER_CLK_EN,
  output logic                           CONV_CLK_EN,
  output logic                           CONV_CLK_RUN,
  output logic                           CONV_GO,
  output logic                           CONV_BUSY,
  output logic                           CONV_GRP
);

  if (SRC_DIV_W != `ACC_SRC_DIV_W || PRESC_W != `ACC_PRESC_W)
  begin : g_bad_w
    $error("acc_top: widths must match the configuration type");
  end

  acc_st_t st_q;
  acc_st_t st_d;

  logic                      src_tick;
  logic                      conv_tick;
  logic                      src_tick_q;
  logic                      conv_tick_q;
  logic [PRESC_W-1:0]        presc_sel;
  logic [PRESC_W-1:0]        presc_eff;
  logic [PRESC_W-1:0]        src_div_ext;
  logic                      susp_sel;
  logic                      imm_sel;
  logic                      queue_any;
  logic                      idle_run;

  assign src_div_ext = {{(PRESC_W-SRC_DIV_W){1'b0}}, st_q.core_cfg.src_div};

  // Source divider runs free off the incoming clock
  // source clock division
  acc_clk_div #(
    .W        (PRESC_W)
  ) u_src_div (
    .CLK      (CLK),
    .RST_B    (RST_B),
    .tick_in  (1'b1),
    .run      (1'b1),
    .div      (src_div_ext),
    .tick_out (src_tick)
  );

  assign presc_sel = st_q.cur_grp ? st_q.core_cfg.prescale1 : st_q.core_cfg.prescale0;

  assign presc_eff = (st_q.core_cfg.src_div != `ACC_SRC_DIV_RST
                      && presc_sel == `ACC_DIV_NONE) ? `ACC_PRESC_FORCED : presc_sel;

  // conversion clock derived from the core source clock
  acc_clk_div #(
    .W        (PRESC_W)
  ) u_conv_div (
    .CLK      (CLK),
    .RST_B    (RST_B),
    .tick_in  (src_tick),
    .run      (st_q.run),
    .div      (presc_eff),
    .tick_out (conv_tick)
  );

  // immediate trigger keeps clock up with a queue enabled
  assign imm_sel   = (st_q.core_cfg.scan_trig == `ACC_TRIG_IMMEDIATE)
                     || (st_q.core_cfg.single_trig == `ACC_TRIG_IMMEDIATE);
  assign queue_any = SCAN_QUEUE_EN || SINGLE_QUEUE_EN;

  // separate suspend controls for scan and single
  assign susp_sel = st_q.cur_scan ? st_q.core_cfg.scan_susp : st_q.core_cfg.single_susp;

  // Idle clock: free running unless a suspend is set
  assign idle_run = !(st_q.core_cfg.scan_susp || st_q.core_cfg.single_susp)
                    || (imm_sel && queue_any);

  always_comb
  begin
    st_d        = st_q;
    st_d.go     = 1'b0;
    st_d.wr_ign = 1'b0;

    if (CFG_WR)
    begin
      if (!MODULE_EN)
        st_d.bus_cfg = CFG_WDATA;
      else
        st_d.wr_ign = 1'b1;
    end

    // enable and configuration cross on core ticks
    if (src_tick)
    begin
      st_d.en_s1 = MODULE_EN;
      st_d.en_s2 = st_q.en_s1;
      // Config only follows while the core is disabled, so it never shifts mid-conversion
      if (!st_q.en_s2)
        st_d.core_cfg = st_q.bus_cfg;
    end

    unique case (st_q.fsm)
      ACC_IDLE:
      begin
        st_d.run = st_q.en_s2 && idle_run;
        if (CONV_REQ && st_q.en_s2)
        begin
          st_d.cur_grp  = CONV_REQ_GRP;
          st_d.cur_scan = CONV_REQ_SCAN;
          st_d.busy     = 1'b1;
          st_d.run      = 1'b1;
          st_d.fsm      = ACC_WAKE;
        end
      end
      ACC_WAKE:
      begin
        // clock restarted before the conversion is released
        st_d.run = 1'b1;
        if (conv_tick)
        begin
          st_d.go  = 1'b1;
          st_d.fsm = ACC_CONV;
        end
      end
      ACC_CONV:
      begin
        st_d.run = 1'b1;
        if (CONV_DONE)
        begin
          st_d.busy = 1'b0;
          st_d.fsm  = ACC_IDLE;
          // stop again after the waking conversion
          st_d.run  = !(susp_sel && !(imm_sel && queue_any)) && st_q.en_s2;
        end
      end
    endcase

    // Disabling aborts any conversion in flight
    if (!st_q.en_s2)
    begin
      st_d.fsm  = ACC_IDLE;
      st_d.busy = 1'b0;
      st_d.run  = 1'b0;
      st_d.go   = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_q                      <= '0;
      st_q.fsm                  <= ACC_IDLE;
      st_q.bus_cfg.src_div      <= `ACC_SRC_DIV_RST;
      st_q.core_cfg.src_div     <= `ACC_SRC_DIV_RST;
      src_tick_q                <= 1'b0;
      conv_tick_q               <= 1'b0;
    end
    else
    begin
      st_q        <= st_d;
      src_tick_q  <= src_tick;
      conv_tick_q <= conv_tick;
    end
  end

  assign CFG_RDATA           = st_q.bus_cfg;
  assign CFG_WR_IGNORED      = st_q.wr_ign;
  assign CORE_EN             = st_q.en_s2;
  assign SRC_CLK_EN          = src_tick_q;
  // warmup prescaler and timer share the source clock
  assign WARMUP_PRESC_CLK_EN = src_tick_q;
  assign TIMER_CLK_EN        = src_tick_q;
  assign CONV_CLK_EN         = conv_tick_q;
  assign CONV_CLK_RUN        = st_q.run;
  assign CONV_GO             = st_q.go;
  assign CONV_BUSY           = st_q.busy;
  assign CONV_GRP            = st_q.cur_grp;

endmodule // acc_top

// *** shared/acc_consts.svh ***
// Field widths, reset values and codes of the converter clock and configuration control
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

`define ACC_SRC_DIV_W      3
`define ACC_PRESC_W        10
`define ACC_MODE_W         2
`define ACC_TRIG_W         4

`define ACC_SRC_DIV_RST    3'h0
`define ACC_PRESC_RST      10'h000
`define ACC_MODE_RST       2'h0
`define ACC_TRIG_RST       4'h0

// Divider value that passes the clock undivided
`define ACC_DIV_NONE       10'h000
// Forced prescaler value (divide by two)
`define ACC_PRESC_FORCED   10'h001
// Trigger select code for software-immediate
`define ACC_TRIG_IMMEDIATE 4'h0

`define ACC_MODE_NORMAL    2'h0
`define ACC_MODE_HSPEED    2'h1
`define ACC_MODE_HACC      2'h2

`endif

// *** shared/acc_pkg.sv ***
// Types of the converter clock and configuration control
package acc_pkg;
  `include "acc_consts.svh"

  typedef struct packed {
    logic [`ACC_SRC_DIV_W-1:0] src_div;
    logic [`ACC_PRESC_W-1:0]   prescale0;
    logic [`ACC_PRESC_W-1:0]   prescale1;
    logic [`ACC_MODE_W-1:0]    mode0;
    logic [`ACC_MODE_W-1:0]    mode1;
    logic                      scan_susp;
    logic                      single_susp;
    logic [`ACC_TRIG_W-1:0]    scan_trig;
    logic [`ACC_TRIG_W-1:0]    single_trig;
  } acc_cfg_t;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'h1,
    ACC_WAKE = 3'h2,
    ACC_CONV = 3'h4
  } acc_fsm_t;

  typedef struct packed {
    acc_cfg_t bus_cfg;
    acc_cfg_t core_cfg;
    logic     en_s1;
    logic     en_s2;
    acc_fsm_t fsm;
    logic     cur_grp;
    logic     cur_scan;
    logic     run;
    logic     go;
    logic     wr_ign;
    logic     busy;
  } acc_st_t;

  typedef struct packed {
    logic [9:0] cnt;
    logic       tick;
  } acc_div_st_t;
endpackage

// *** rtl/acc_clk_div.sv ***
// Tick divider: one output pulse every (div+1) input ticks while running
`timescale 1ns/1ps
module acc_clk_div
  import acc_pkg::*;
#(
  parameter int W = 10
)
(
  input  wire logic         CLK,
  input  wire logic         RST_B,
  input  wire logic         tick_in,
  input  wire logic         run,
  input  wire logic [W-1:0] div,
  output logic              tick_out
);

  if (W < 1 || W > 10)
  begin : g_bad_w
    $error("acc_clk_div: W must be 1 to 10");
  end

  acc_div_st_t st_q;
  acc_div_st_t st_d;

  always_comb
  begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (!run)
      // Stopped clock restarts from a full period, no runt pulse
      st_d.cnt = 10'h000;
    else if (tick_in)
    begin
      if (st_q.cnt[W-1:0] >= div)
      begin
        st_d.cnt  = 10'h000;
        st_d.tick = 1'b1;
      end
      else
        st_d.cnt = st_q.cnt + 10'h001;
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign tick_out = st_q.tick;

endmodule // acc_clk_div

// *** verif/acc_assertions.sv ***
// Checker of the converter clock and configuration control
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_checker
  import acc_pkg::*;
(
  input wire logic     CLK,
  input wire logic     RST_B,
  input wire logic     MODULE_EN,
  input wire logic     CFG_WR,
  input wire acc_cfg_t CFG_WDATA,
  input wire logic     SCAN_QUEUE_EN,
  input wire logic     SINGLE_QUEUE_EN,
  input wire logic     CONV_REQ,
  input wire logic     CONV_REQ_GRP,
  input wire logic     CONV_DONE,
  input wire acc_cfg_t CFG_RDATA,
  input wire logic     CFG_WR_IGNORED,
  input wire logic     CORE_EN,
  input wire logic     SRC_CLK_EN,
  input wire logic     WARMUP_PRESC_CLK_EN,
  input wire logic     TIMER_CLK_EN,
  input wire logic     CONV_CLK_RUN,
  input wire logic     CONV_GO,
  input wire logic     CONV_BUSY,
  input wire logic     CONV_GRP
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic gone_q;
  logic gone_d;
  logic keep;
  logic susp;
  // A done before the conversion is released is ignored, so only count it after go
  always_comb gone_d = CONV_BUSY & (gone_q | CONV_GO);
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B) gone_q <= 1'b0;
    else gone_q <= gone_d;
  assign keep = (CFG_RDATA.scan_trig == `ACC_TRIG_IMMEDIATE
    || CFG_RDATA.single_trig == `ACC_TRIG_IMMEDIATE) && (SCAN_QUEUE_EN || SINGLE_QUEUE_EN);
  assign susp = CFG_RDATA.scan_susp & CFG_RDATA.single_susp;
  sequence s_take; CONV_REQ && CORE_EN && !CONV_BUSY; endsequence
  sequence s_done; gone_q && CONV_DONE; endsequence
  property p_wr_ok; CFG_WR && !MODULE_EN |=> CFG_RDATA == $past(CFG_WDATA); endproperty
  property p_wr_ign; CFG_WR && MODULE_EN |=> CFG_WR_IGNORED && $stable(CFG_RDATA); endproperty
  property p_ign_why; CFG_WR_IGNORED |-> $past(CFG_WR) && $past(MODULE_EN); endproperty
  property p_fan; SRC_CLK_EN == WARMUP_PRESC_CLK_EN && SRC_CLK_EN == TIMER_CLK_EN; endproperty
  property p_sync; $rose(CORE_EN) |-> $past(MODULE_EN, 2); endproperty
  property p_take; s_take |=> CONV_BUSY && CONV_CLK_RUN; endproperty
  property p_grp; s_take |=> CONV_GRP == $past(CONV_REQ_GRP); endproperty
  property p_go; CONV_GO |-> CONV_CLK_RUN && CONV_BUSY; endproperty
  property p_end; s_done |=> !CONV_BUSY; endproperty
  property p_stop; s_done ##0 (susp && !keep) |=> !CONV_CLK_RUN; endproperty
  property p_keep; s_done ##0 keep |=> CONV_CLK_RUN; endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("write not taken");
  a_wr_ign: assert property (p_wr_ign) else $error("locked write not refused");
  a_ign_why: assert property (p_ign_why) else $error("stray ignore flag");
  a_fan: assert property (p_fan) else $error("source tick fan-out differs");
  a_sync: assert property (p_sync) else $error("core enable too early");
  a_take: assert property (p_take) else $error("request not started");
  a_grp: assert property (p_grp) else $error("wrong group");
  a_go: assert property (p_go) else $error("go without running clock");
  a_end: assert property (p_end) else $error("busy after done");
  a_stop: assert property (p_stop) else $error("clock not suspended");
  a_keep: assert property (p_keep) else $error("clock stopped with queue on");
endmodule // acc_checker
bind acc_top acc_checker u_chk (.*);

// *** verif/acc_top_tb_top.sv ***
// Self-checking bench of the converter clock and configuration control
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_top_tb_top
  import acc_pkg::*;
;
  logic CLK, RST_B, MODULE_EN, CFG_WR, SCAN_QUEUE_EN, SINGLE_QUEUE_EN;
  logic CONV_REQ, CONV_REQ_SCAN, CONV_REQ_GRP, CONV_DONE, CFG_WR_IGNORED, CORE_EN;
  logic SRC_CLK_EN, WARMUP_PRESC_CLK_EN, TIMER_CLK_EN, CONV_CLK_EN, CONV_CLK_RUN;
  logic CONV_GO, CONV_BUSY, CONV_GRP;
  acc_cfg_t CFG_WDATA, CFG_RDATA, m, d;
  logic [39:0] tmp;
  logic [7:0] lf = 8'h45;
  int err_total = 0;
  int tests_run = 0;
  int n;
  acc_top dut (.*);
  // Bench clock stands for the incoming converter clock; only cycle ratios are checked
  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  function automatic logic sig(input int k);
    case (k)
      0: return CORE_EN;
      1: return CONV_GO;
      2: return CONV_CLK_EN;
      default: return SRC_CLK_EN;
    endcase
  endfunction
  task automatic finish_test();
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [36:0] g, input logic [36:0] e, input string s);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %0t %s", $time, s);
    end
  endtask
  // Cycles up to and including the next pulse, bounded
  task automatic wt(input int k, output int c);
    c = 0;
    do
    begin
      @(posedge CLK);
      #1;
      c++;
    end
    while (sig(k) !== 1'b1 && c < 300);
    if (c >= 300)
    begin
      chk(1'b0, 1'b1, "wait timed out");
      finish_test();
    end
  endtask
  task automatic wr(input acc_cfg_t v);
    @(posedge CLK);
    CFG_WR <= 1'b1;
    CFG_WDATA <= v;
    @(posedge CLK);
    CFG_WR <= 1'b0;
    #1;
    if (!MODULE_EN)
      m = v;
    chk(CFG_RDATA, m, "readback");
    chk(CFG_WR_IGNORED, MODULE_EN, "ignore flag");
  endtask
  task automatic conv(input logic g, input logic s, input logic q, input int p, input logic r);
    @(posedge CLK);
    SINGLE_QUEUE_EN <= q;
    CONV_REQ <= 1'b1;
    CONV_REQ_SCAN <= s;
    CONV_REQ_GRP <= g;
    @(posedge CLK);
    CONV_REQ <= 1'b0;
    #1;
    chk(CONV_BUSY, 1'b1, "busy");
    chk(CONV_GRP, g, "group");
    wt(1, n);
    wt(2, n);
    wt(2, n);
    chk(n, p, "conversion clock period");
    @(posedge CLK);
    CONV_DONE <= 1'b1;
    @(posedge CLK);
    CONV_DONE <= 1'b0;
    @(posedge CLK);
    #1;
    chk(CONV_BUSY, 1'b0, "busy after done");
    chk(CONV_CLK_RUN, r, "clock after done");
  endtask
  initial
  begin
    {RST_B, MODULE_EN, CFG_WR, SCAN_QUEUE_EN, SINGLE_QUEUE_EN} = '0;
    {CONV_REQ, CONV_REQ_SCAN, CONV_REQ_GRP, CONV_DONE} = '0;
    CFG_WDATA = '0;
    m = '0;
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    #1;
    chk(CFG_RDATA, 37'h0, "reset value");
    for (int i = 0; i < 5; i++)
    begin
      tmp = {rnd(), rnd(), rnd(), rnd(), rnd()};
      wr(tmp[36:0]);
    end
    // Locked setup while disabled, then enable, then the rest, then a queue
    // Source clock 31.25 MHz, group clocks 15.6 and 4.5 MHz
    d = '0;
    d.src_div = 3'h3;
    d.prescale1 = 10'h006;
    d.mode0 = `ACC_MODE_HSPEED;
    d.mode1 = `ACC_MODE_HACC;
    d.scan_susp = 1'b1;
    d.single_susp = 1'b1;
    d.scan_trig = 4'h1;
    d.single_trig = `ACC_TRIG_IMMEDIATE;
    wr(d);
    // Request before the core is enabled is refused
    @(posedge CLK);
    CONV_REQ <= 1'b1;
    @(posedge CLK);
    CONV_REQ <= 1'b0;
    #1;
    chk(CONV_BUSY, 1'b0, "request while disabled");
    chk(CONV_CLK_RUN, 1'b0, "clock while disabled");
    // Let the core copy settle so the source period is steady
    repeat (16) @(posedge CLK);
    MODULE_EN <= 1'b1;
    wt(0, n);
    chk(n >= 5 && n <= 8, 1'b1, "enable crossing time");
    tmp = {rnd(), rnd(), rnd(), rnd(), rnd()};
    wr(tmp[36:0]);
    wt(3, n);
    wt(3, n);
    chk(n, 4, "source tick period");
    chk(CONV_CLK_RUN, 1'b0, "idle suspended");
    conv(1'b0, 1'b1, 1'b0, 8, 1'b0);
    conv(1'b1, 1'b0, 1'b1, 28, 1'b1);
    finish_test();
  end
endmodule // acc_top_tb_top
